// File: anpr_top.sv
// Auto-negotiation page register bank with APB slave and interrupt.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module anpr_top
	import anpr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic page_rx_strobe,
	input wire logic [47:0] page_rx_data,
	input wire logic fault_detect,
	input wire logic negotiation_done_in,
	input wire logic link_up_in,
	input wire logic next_page_sent,
	output logic negotiation_soft_reset,
	output logic negotiation_active,
	output logic negotiation_restart_pulse,
	output logic [47:0] base_page_tx,
	output logic [31:0] next_page_tx
);
	anpr_seq_if sif();

	anpr_seq anpr_seq_inst (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.sif(sif)
	);

	// Sticky flag update: a hardware set wins over a clear in the same cycle.
	function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction

	// Decodes a register index to a mapped/unmapped answer.
	function automatic logic idx_hit(input logic [9:0] idx);
		unique case (idx)
			CTRL_IDX, STAT_IDX, BPL_IDX, BPM_IDX, BPH_IDX,
			PPL_IDX, PPM_IDX, PPH_IDX, NPL_IDX, NPM_IDX,
			IRQ_STAT_IDX, IRQ_MASK_IDX: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Write strobe for one register, so every writer decodes the address alike.
	function automatic logic wr_at(input logic en, input logic [9:0] at,
		input logic [9:0] want);
		return en && (at == want);
	endfunction

	logic [9:0] idx;
	logic aligned;
	logic setup;
	logic wr_en;
	logic [15:0] wd;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [15:0] rd_mux;
	logic irq_r;

	logic en_r;
	logic restart_r;
	logic page_r;
	logic done_r;
	logic fault_r;
	logic link_r;
	logic [15:0] bpl_r;
	logic [15:0] bpm_r;
	logic [15:0] bph_r;
	logic [15:0] ppl_r;
	logic [15:0] ppm_r;
	logic [15:0] pph_r;
	logic [15:0] npl_r;
	logic [15:0] npm_r;
	logic toggle_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] irq_ev;
	logic done_prev_r;
	logic link_prev_r;

	assign idx = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign setup = psel & ~penable;
	// A write takes effect only at the access edge where pready is high.
	assign wr_en = psel & penable & pwrite & pready_r & aligned;
	assign wd = pwdata[15:0];

	// Every transfer completes with one wait-free access phase.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (ce) begin
			pready_r <= setup;
			pslverr_r <= setup & ~(aligned & idx_hit(idx));
			if (setup) begin
				prdata_r <= {16'h0000, rd_mux};
			end
		end
	end

	// Reserved and unmapped bits read as zero.
	always_comb begin
		rd_mux = 16'h0000;
		if (aligned) begin
			unique case (idx)
				CTRL_IDX: begin
					rd_mux[CTL_RST_BIT] = sif.in_reset;
					rd_mux[CTL_EN_BIT] = en_r;
					rd_mux[CTL_RESTART_BIT] = restart_r;
				end
				STAT_IDX: begin
					rd_mux[ST_PAGE_BIT] = page_r;
					rd_mux[ST_DONE_BIT] = done_r;
					rd_mux[ST_FAULT_BIT] = fault_r;
					rd_mux[ST_ABLE_BIT] = ABLE_VALUE;
					rd_mux[ST_LINK_BIT] = link_r;
				end
				BPL_IDX: rd_mux = bpl_r;
				BPM_IDX: rd_mux = bpm_r;
				BPH_IDX: rd_mux = bph_r;
				PPL_IDX: rd_mux = ppl_r;
				PPM_IDX: rd_mux = ppm_r;
				PPH_IDX: rd_mux = pph_r;
				NPL_IDX: begin
					rd_mux = npl_r;
					rd_mux[NP_TOGGLE_BIT] = toggle_r;
				end
				NPM_IDX: rd_mux = npm_r;
				IRQ_STAT_IDX: rd_mux[IRQ_W-1:0] = irq_stat_r;
				IRQ_MASK_IDX: rd_mux[IRQ_W-1:0] = irq_mask_r;
				default: rd_mux = 16'h0000;
			endcase
		end
	end

	// Control: the enable bit.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			en_r <= EN_RESET;
		end else if (ce && wr_at(wr_en, idx, CTRL_IDX)) begin
			en_r <= wd[CTL_EN_BIT];
		end
	end

	// The sequencer takes the restart request in the cycle after it is set.
	// A restart written with the enable bit low is dropped, since nothing would run.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			restart_r <= 1'b0;
		end else if (ce) begin
			if (restart_r) begin
				restart_r <= 1'b0;
			end else if (wr_at(wr_en, idx, CTRL_IDX)) begin
				restart_r <= wd[CTL_RESTART_BIT] & wd[CTL_EN_BIT];
			end
		end
	end

	assign sif.enable = en_r;
	assign sif.restart = restart_r;

	// Page arrived flag: a write of zero clears it, a write of one keeps it.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			page_r <= 1'b0;
		end else if (ce) begin
			page_r <= flag_upd(page_r, page_rx_strobe,
				wr_at(wr_en, idx, STAT_IDX) && !wd[ST_PAGE_BIT]);
		end
	end

	// Remote fault flag, cleared the same way as the page flag.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			fault_r <= 1'b0;
		end else if (ce) begin
			fault_r <= flag_upd(fault_r, fault_detect,
				wr_at(wr_en, idx, STAT_IDX) && !wd[ST_FAULT_BIT]);
		end
	end

	// Completion counts only while the function runs, so a stale engine level reads zero.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			done_r <= 1'b0;
		end else if (ce) begin
			done_r <= negotiation_done_in & sif.running;
		end
	end

	// Link state mirror; software cannot alter it.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			link_r <= 1'b0;
		end else if (ce) begin
			link_r <= link_up_in;
		end
	end

	// Local base page words.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bpl_r <= BPL_RESET;
		end else if (ce && wr_at(wr_en, idx, BPL_IDX)) begin
			bpl_r <= wd & BPL_WMASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bpm_r <= 16'h0000;
		end else if (ce && wr_at(wr_en, idx, BPM_IDX)) begin
			bpm_r <= wd;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bph_r <= 16'h0000;
		end else if (ce && wr_at(wr_en, idx, BPH_IDX)) begin
			bph_r <= wd;
		end
	end

	// Partner base page is captured whole so the three words stay coherent.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ppl_r <= 16'h0000;
			ppm_r <= 16'h0000;
			pph_r <= 16'h0000;
		end else if (ce && page_rx_strobe) begin
			ppl_r <= page_rx_data[15:0];
			ppm_r <= page_rx_data[31:16];
			pph_r <= page_rx_data[47:32];
		end
	end

	// Local next page words.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			npl_r <= 16'h0000;
		end else if (ce && wr_at(wr_en, idx, NPL_IDX)) begin
			npl_r <= wd & NPL_WMASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			npm_r <= 16'h0000;
		end else if (ce && wr_at(wr_en, idx, NPM_IDX)) begin
			npm_r <= wd;
		end
	end

	// The toggle is kept by hardware and starts from zero after every soft reset.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			toggle_r <= 1'b0;
		end else if (ce) begin
			if (sif.in_reset) begin
				toggle_r <= 1'b0;
			end else if (next_page_sent) begin
				toggle_r <= ~toggle_r;
			end
		end
	end

	// Interrupt events: page, completion rising, fault, link change.
	assign irq_ev[IRQ_PAGE_BIT] = page_rx_strobe;
	assign irq_ev[IRQ_DONE_BIT] = done_r & ~done_prev_r;
	assign irq_ev[IRQ_FAULT_BIT] = fault_detect;
	assign irq_ev[IRQ_LINK_BIT] = link_r ^ link_prev_r;

	// Previous levels for the edge events.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			done_prev_r <= 1'b0;
			link_prev_r <= 1'b0;
		end else if (ce) begin
			done_prev_r <= done_r;
			link_prev_r <= link_r;
		end
	end

	// Interrupt status: set by events, cleared by writing one; a set wins.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			irq_stat_r <= '0;
		end else if (ce) begin
			for (int i = 0; i < IRQ_W; i++) begin
				irq_stat_r[i] <= flag_upd(irq_stat_r[i], irq_ev[i],
					wr_at(wr_en, idx, IRQ_STAT_IDX) && wd[i]);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			irq_mask_r <= '0;
		end else if (ce && wr_at(wr_en, idx, IRQ_MASK_IDX)) begin
			irq_mask_r <= wd[IRQ_W-1:0];
		end
	end

	// One cycle behind the status bits, so the output stays glitch-free.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			irq_r <= 1'b0;
		end else if (ce) begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign negotiation_soft_reset = sif.in_reset;
	assign negotiation_active = sif.running;
	assign negotiation_restart_pulse = sif.restart_pulse;
	assign base_page_tx = {bph_r, bpm_r, bpl_r};
	assign next_page_tx = {npm_r, npl_r[15:12], toggle_r, npl_r[10:0]};
endmodule

// File: anpr_pkg.sv
// Shared constants for the auto-negotiation page register bank.
package anpr_pkg;
	// Register indices; the APB byte address is four times the index.
	localparam logic [9:0] CTRL_IDX = 10'h200;
	localparam logic [9:0] STAT_IDX = 10'h201;
	localparam logic [9:0] BPL_IDX = 10'h202;
	localparam logic [9:0] BPM_IDX = 10'h203;
	localparam logic [9:0] BPH_IDX = 10'h204;
	localparam logic [9:0] PPL_IDX = 10'h205;
	localparam logic [9:0] PPM_IDX = 10'h206;
	localparam logic [9:0] PPH_IDX = 10'h207;
	localparam logic [9:0] NPL_IDX = 10'h208;
	localparam logic [9:0] NPM_IDX = 10'h209;
	localparam logic [9:0] IRQ_STAT_IDX = 10'h2f0;
	localparam logic [9:0] IRQ_MASK_IDX = 10'h2f1;
	// Control and status fields.
	localparam int CTL_RST_BIT = 15;
	localparam int CTL_EN_BIT = 12;
	localparam int CTL_RESTART_BIT = 9;
	localparam int ST_PAGE_BIT = 6;
	localparam int ST_DONE_BIT = 5;
	localparam int ST_FAULT_BIT = 4;
	localparam int ST_ABLE_BIT = 3;
	localparam int ST_LINK_BIT = 2;
	localparam int NP_TOGGLE_BIT = 11;
	// Interrupt status and mask layout.
	localparam int IRQ_PAGE_BIT = 0;
	localparam int IRQ_DONE_BIT = 1;
	localparam int IRQ_FAULT_BIT = 2;
	localparam int IRQ_LINK_BIT = 3;
	localparam int IRQ_W = 4;
	// Reset values.
	localparam logic EN_RESET = 1'h1;
	localparam logic ABLE_VALUE = 1'h1;
	localparam logic [15:0] BPL_RESET = 16'h0001;
	// Writable bits; the acknowledge bit and the toggle bit are excluded.
	localparam logic [15:0] BPL_WMASK = 16'hbfff;
	localparam logic [15:0] NPL_WMASK = 16'hb7ff;
	// Soft reset duration of the negotiation function.
	localparam int CLK_PERIOD_NS = 10;
	localparam int SOFT_RST_NS = 100;
	localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEQ_CNT_W = 8;
	typedef enum logic [1:0] {
		SEQ_OFF = 2'b00,
		SEQ_RST = 2'b01,
		SEQ_RUN = 2'b10
	} anpr_seq_t;
endpackage

// File: anpr_seq_if.sv
// Control link between the register bank and the negotiation sequencer.
`timescale 1ns/10ps
interface anpr_seq_if;
	logic enable;
	logic restart;
	logic in_reset;
	logic running;
	logic restart_pulse;
	modport regs (output enable, output restart, input in_reset, input running,
		input restart_pulse);
	modport seq (input enable, input restart, output in_reset, output running,
		output restart_pulse);
endinterface

// File: anpr_seq.sv
// Negotiation sequencer: soft reset timing, enable and restart handling.
`timescale 1ns/10ps
module anpr_seq
	import anpr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	anpr_seq_if.seq sif
);
	anpr_seq_t state_r;
	logic [SEQ_CNT_W-1:0] cnt_r;
	logic rst_r;
	logic run_r;
	logic pulse_r;

	// The function always passes through a timed reset before it runs.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_r <= SEQ_RST;
			cnt_r <= SEQ_CNT_W'(SOFT_RST_CYC - 1);
		end else if (ce) begin
			unique case (state_r)
				SEQ_OFF: begin
					if (sif.enable) begin
						state_r <= SEQ_RST;
						cnt_r <= SEQ_CNT_W'(SOFT_RST_CYC - 1);
					end
				end
				SEQ_RST: begin
					if (sif.restart) begin
						cnt_r <= SEQ_CNT_W'(SOFT_RST_CYC - 1);
					end else if (cnt_r == '0) begin
						state_r <= sif.enable ? SEQ_RUN : SEQ_OFF;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				SEQ_RUN: begin
					if (!sif.enable) begin
						state_r <= SEQ_OFF;
					end else if (sif.restart) begin
						state_r <= SEQ_RST;
						cnt_r <= SEQ_CNT_W'(SOFT_RST_CYC - 1);
					end
				end
				default: begin
					state_r <= SEQ_OFF;
				end
			endcase
		end
	end

	// Soft reset flag clears itself when the timed reset ends.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rst_r <= 1'b1;
			run_r <= 1'b0;
			pulse_r <= 1'b0;
		end else if (ce) begin
			// Raised on the edge that enters the timed reset, so it lasts the full count.
			rst_r <= ((state_r == SEQ_RST) && !(cnt_r == '0 && !sif.restart)) ||
				(state_r == SEQ_RUN && sif.enable && sif.restart) ||
				(state_r == SEQ_OFF && sif.enable);
			run_r <= (state_r == SEQ_RUN && sif.enable && !sif.restart) ||
				(state_r == SEQ_RST && cnt_r == '0 && !sif.restart && sif.enable);
			pulse_r <= sif.restart && sif.enable;
		end
	end

	assign sif.in_reset = rst_r;
	assign sif.running = run_r;
	assign sif.restart_pulse = pulse_r;
endmodule

// File: anpr_partner.sv
// Model of the remote link partner that delivers received base pages.
`timescale 1ns/10ps
module anpr_partner (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic [47:0] page,
	output logic page_rx_strobe,
	output logic [47:0] page_rx_data
);
	initial begin
		page_rx_strobe = 1'b0;
		page_rx_data = 48'h0;
	end
	// Outside the strobe the data lines flip, so a late capture cannot pass by luck.
	always @(posedge ref_clk) begin
		page_rx_strobe <= go;
		page_rx_data <= go ? page : ~page_rx_data;
	end
endmodule

// File: anpr_assertions.sv
// Concurrent checks on the port behaviour of the page register bank.
`timescale 1ns/10ps
module anpr_chk
	import anpr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic negotiation_soft_reset,
	input wire logic negotiation_active,
	input wire logic negotiation_restart_pulse,
	input wire logic [47:0] base_page_tx
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic setup;
	assign setup = psel && !penable && ce;
	sequence bpm_write;
		setup && pwrite && paddr == {BPM_IDX, 2'b00} ##1 pready;
	endsequence
	sequence rst_run;
		negotiation_soft_reset [*8];
	endsequence
	AST_PREADY_NEXT: assert property (setup |=> pready)
		else $error("no answer after setup");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_UNMAPPED: assert property (setup && !paddr[11] |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_PRDATA_TOP: assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	AST_WRITE_BPM: assert property (bpm_write |=> base_page_tx[31:16] == $past(pwdata[15:0]))
		else $error("base page word two not written");
	AST_RST_EXCL: assert property (negotiation_soft_reset |-> !negotiation_active)
		else $error("active during soft reset");
	AST_RST_HOLD: assert property ($rose(negotiation_soft_reset) |-> rst_run)
		else $error("soft reset too short");
	AST_RST_END: assert property ($rose(negotiation_soft_reset) |-> ##[9:11] !negotiation_soft_reset)
		else $error("soft reset does not clear");
	AST_RESTART: assert property (negotiation_restart_pulse |=> !negotiation_restart_pulse)
		else $error("restart pulse not single");
	AST_ACK_ZERO: assert property (base_page_tx[14] == 1'b0)
		else $error("acknowledge bit set");
endmodule
bind anpr_top anpr_chk anpr_chk_inst (.ref_clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .negotiation_soft_reset, .negotiation_active,
	.negotiation_restart_pulse, .base_page_tx);

// File: anpr_top_test.sv
// Self-checking bench for the page register bank over APB.
`timescale 1ns/10ps
module anpr_top_test;
	import anpr_pkg::*;
	logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, go, err;
	logic fault_detect, negotiation_done_in, link_up_in, page_rx_strobe;
	logic negotiation_soft_reset, negotiation_active, negotiation_restart_pulse;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, next_page_tx;
	logic [47:0] page, page_rx_data, base_page_tx;
	logic [15:0] rexp [1:9] = '{16'h8, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
	logic [15:0] wexp [1:9] = '{16'h8, 16'hbfff, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0,
		16'hb7ff, 16'hffff};
	int num_errors = 0, cmp_count = 0, cyc = 0, pulses = 0;
	anpr_top anpr_top_inst (.ref_clk, .rstn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq, .page_rx_strobe, .page_rx_data,
		.fault_detect, .negotiation_done_in, .link_up_in, .next_page_sent(1'b0),
		.negotiation_soft_reset, .negotiation_active, .negotiation_restart_pulse,
		.base_page_tx, .next_page_tx);
	anpr_partner anpr_partner_inst (.ref_clk, .go, .page, .page_rx_strobe, .page_rx_data);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic report_and_stop();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// The whole run needs well under a thousand cycles.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (negotiation_restart_pulse === 1'b1)
			pulses <= pulses + 1;
		if (cyc == 3000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0, wd};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 16'h0);
		chk(rd, {16'h0, exp});
	endtask
	initial begin
		{rstn, psel, penable, pwrite, go, fault_detect, negotiation_done_in, link_up_in} = 8'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		page = 48'h0;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		rdc(CTRL_IDX, 16'h9000);
		repeat (40) if (negotiation_active !== 1'b1) @(posedge ref_clk);
		rdc(CTRL_IDX, 16'h1000);
		for (int i = 1; i < 10; i++) rdc(10'(CTRL_IDX + i), rexp[i]);
		$display("reset values done");
		for (int i = 1; i < 10; i++) apb(1'b1, 10'(CTRL_IDX + i), 16'hffff);
		for (int i = 1; i < 10; i++) rdc(10'(CTRL_IDX + i), wexp[i]);
		chk(next_page_tx, 32'hffffb7ff);
		apb(1'b0, 10'h001, 16'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		$display("access kinds done");
		page <= 48'h123456789abc;
		go <= 1'b1;
		fault_detect <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		fault_detect <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rdc(PPL_IDX, 16'h9abc);
		rdc(PPM_IDX, 16'h5678);
		rdc(PPH_IDX, 16'h1234);
		rdc(STAT_IDX, 16'h0058);
		chk({31'h0, irq}, 32'h0);
		rdc(IRQ_STAT_IDX, 16'h5);
		apb(1'b1, IRQ_MASK_IDX, 16'h1);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, IRQ_STAT_IDX, 16'h1);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		rdc(IRQ_STAT_IDX, 16'h4);
		apb(1'b1, STAT_IDX, 16'h0040);
		rdc(STAT_IDX, 16'h0048);
		apb(1'b1, STAT_IDX, 16'h0000);
		rdc(STAT_IDX, 16'h0008);
		$display("events done");
		negotiation_done_in <= 1'b1;
		link_up_in <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdc(STAT_IDX, 16'h002c);
		apb(1'b1, CTRL_IDX, 16'h0200);
		rdc(CTRL_IDX, 16'h0000);
		rdc(STAT_IDX, 16'h000c);
		chk(32'(pulses), 32'h0);
		apb(1'b1, CTRL_IDX, 16'h1000);
		repeat (20) @(posedge ref_clk);
		apb(1'b1, CTRL_IDX, 16'h1200);
		rdc(CTRL_IDX, 16'h9000);
		chk(32'(pulses), 32'h1);
		$display("control done");
		report_and_stop();
	end
endmodule
